// [hw/clock_output_channel_pkg.sv]
// Purpose: shared constants for one clock output channel
// Assumes: 8-bit register port, one input clock domain
// Notes: offsets are register addresses on the serial control port
package clock_output_channel_pkg;
  // register addresses
  localparam logic [7:0] ADDR_RATIO_LOW = 8'h1B;
  localparam logic [7:0] ADDR_RATIO_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_PHASE_LOW = 8'h1D;
  localparam logic [7:0] ADDR_PHASE_HIGH = 8'h1E;
  localparam logic [7:0] ADDR_DRIVER_CTRL = 8'h1F;
  localparam logic [7:0] ADDR_SINGLE_CTRL = 8'h20;
  // values after reset
  localparam logic [9:0] RESET_RATIO = 10'h000;
  localparam logic [10:0] RESET_PHASE = 11'h000;
  localparam logic [7:0] RESET_DRIVER_CTRL = 8'h14;
  localparam logic [7:0] RESET_SINGLE_CTRL = 8'h00;
  // field positions in the driver control register
  localparam int POS_POWERDOWN = 7;
  localparam int POS_SYNC_EXCLUDE = 6;
  localparam int POS_DIFF_POL = 4;
  localparam int POS_DIFF_STD = 1;
  // field positions in the single-ended control register
  localparam int POS_POS_ENABLE = 7;
  localparam int POS_POS_POL = 5;
  localparam int POS_NEG_ENABLE = 4;
  localparam int POS_NEG_POL = 2;
  // polarity codes shared by all three drivers
  localparam logic [1:0] POL_FORCE_HIGH = 2'h0;
  localparam logic [1:0] POL_NONINVERT = 2'h1;
  localparam logic [1:0] POL_INVERT = 2'h2;
  localparam logic [1:0] POL_FORCE_LOW = 2'h3;
  // driver standard codes
  localparam logic [2:0] STD_HSTL_NORMAL = 3'h4;
  localparam logic [2:0] STD_HSTL_BOOST = 3'h5;
  localparam logic [2:0] STD_SINGLE_FIRST = 3'h6;
  typedef enum logic [1:0] {
    DIV_HALT = 2'b00,
    DIV_DELAY = 2'b01,
    DIV_RUN = 2'b10
  } div_state_type;
endpackage

// [hw/divider_cfg_if.sv]
// Purpose: carries divider settings in and divided clock out
// Assumes: single clock domain
// Notes: ctrl side owns the settings, div side owns the outputs
`timescale 1ns/1ns
interface divider_cfg_if;
  logic [9:0] ratio;
  logic [10:0] phase;
  logic powerdown;
  logic syncPulse;
  logic divClk;
  logic halfShift;
  modport ctrl (output ratio, output phase, output powerdown, output syncPulse,
    input divClk, input halfShift);
  modport div (input ratio, input phase, input powerdown, input syncPulse,
    output divClk, output halfShift);
endinterface

// [hw/channel_divider.sv]
// Purpose: integer divider with coarse start offset for one channel
// Assumes: settings come from registers on the same clock
// Notes: half-period part of the offset is reported, not applied here
`timescale 1ns/1ns
module channel_divider (
  input wire logic clk,
  input wire logic rst,
  divider_cfg_if.div cfg
);
  clock_output_channel_pkg::div_state_type state, next_state;
  logic [9:0] cnt, next_cnt;
  logic [9:0] dly, next_dly;
  logic outReg, next_outReg;
  logic half, next_half;

  // high for the first half (rounded up) of each divided period
  function automatic logic isHigh(input logic [9:0] c, input logic [9:0] r);
    logic [10:0] lim;
    lim = ({1'b0, r} + 11'h002) >> 1;
    return {1'b0, c} < lim;
  endfunction

  // next state; powerdown beats sync, sync beats counting
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_dly = dly;
    next_outReg = outReg;
    next_half = half;
    if (cfg.powerdown) begin
      next_state = clock_output_channel_pkg::DIV_HALT;
      next_cnt = 10'h000;
      next_outReg = 1'b0;
    end else if (cfg.syncPulse || state == clock_output_channel_pkg::DIV_HALT) begin
      next_state = clock_output_channel_pkg::DIV_DELAY;
      next_dly = cfg.phase[10:1];
      next_half = cfg.phase[0];
      next_cnt = 10'h000;
      next_outReg = 1'b0;
    end else begin
      unique case (state)
        clock_output_channel_pkg::DIV_DELAY: begin
          if (dly == 10'h000) begin
            next_state = clock_output_channel_pkg::DIV_RUN;
            next_outReg = isHigh(10'h000, cfg.ratio);
          end else begin
            next_dly = dly - 10'h001;
          end
        end
        clock_output_channel_pkg::DIV_RUN: begin
          next_cnt = (cnt >= cfg.ratio) ? 10'h000 : cnt + 10'h001;
          next_outReg = isHigh(next_cnt, cfg.ratio);
        end
        default: begin
          next_state = clock_output_channel_pkg::DIV_HALT;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= clock_output_channel_pkg::DIV_HALT;
      cnt <= 10'h000;
      dly <= 10'h000;
      outReg <= 1'b0;
      half <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dly <= next_dly;
      outReg <= next_outReg;
      half <= next_half;
    end
  end

  assign cfg.divClk = outReg;
  assign cfg.halfShift = half;

  chk_count_wraps: assert property (@(posedge clk) disable iff (rst)
    (state == clock_output_channel_pkg::DIV_RUN && cnt >= cfg.ratio
      && !cfg.powerdown && !cfg.syncPulse) |=> cnt == 10'h000)
    else $error("divider did not wrap at ratio");
  chk_offset_load: assert property (@(posedge clk) disable iff (rst)
    (cfg.syncPulse && !cfg.powerdown) |=> (dly == $past(cfg.phase[10:1])
      && half == $past(cfg.phase[0]) && !outReg))
    else $error("offset not loaded on sync");
  chk_powerdown_static: assert property (@(posedge clk) disable iff (rst)
    cfg.powerdown ##1 cfg.powerdown ##1 cfg.powerdown |-> !outReg && $stable(outReg))
    else $error("divider output moved in powerdown");
  cover_wrap: cover property (@(posedge clk) disable iff (rst)
    state == clock_output_channel_pkg::DIV_RUN && cnt == cfg.ratio && cnt != 10'h000);
endmodule // channel_divider

// [hw/clock_output_channel_ctrl.sv]
// Purpose: control logic of one clock output channel
// Assumes: clk is the channel input clock; register port on same clock;
//   syncReq comes from a pin and is synchronised here
// Notes: drivers' analog settings leave on diffStandard
`timescale 1ns/1ns
module clock_output_channel_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  input wire logic syncReq,
  output logic chanPosPin,
  output logic chanPosOe,
  output logic chanNegPin,
  output logic chanNegOe,
  output logic [2:0] diffStandard,
  output logic halfShift
);
  divider_cfg_if cfgBus ();

  logic [9:0] chanDivideRatio, next_chanDivideRatio;
  logic [10:0] chanPhaseOffset, next_chanPhaseOffset;
  logic [7:0] driverCtrl, next_driverCtrl;
  logic [7:0] singleCtrl, next_singleCtrl;
  logic [7:0] next_regRdData;
  logic syncMeta, syncSafe, syncLast, syncPulse;
  logic next_syncPulse;
  logic next_chanPosPin, next_chanPosOe, next_chanNegPin, next_chanNegOe;
  logic [2:0] next_diffStandard;
  logic next_halfShift;

  // field views of the control registers
  logic dividerPowerdown;
  logic syncExclude;
  logic [1:0] diffDriverPolarity;
  logic [2:0] diffDriverStandard;
  logic posLegSingleEnable, negLegSingleEnable;
  logic [1:0] posLegSinglePolarity, negLegSinglePolarity;
  logic singleMode;
  logic syncEdge;

  assign dividerPowerdown = driverCtrl[clock_output_channel_pkg::POS_POWERDOWN];
  assign syncExclude = driverCtrl[clock_output_channel_pkg::POS_SYNC_EXCLUDE];
  assign diffDriverPolarity = driverCtrl[clock_output_channel_pkg::POS_DIFF_POL +: 2];
  assign diffDriverStandard = driverCtrl[clock_output_channel_pkg::POS_DIFF_STD +: 3];
  assign posLegSingleEnable = singleCtrl[clock_output_channel_pkg::POS_POS_ENABLE];
  assign posLegSinglePolarity = singleCtrl[clock_output_channel_pkg::POS_POS_POL +: 2];
  assign negLegSingleEnable = singleCtrl[clock_output_channel_pkg::POS_NEG_ENABLE];
  assign negLegSinglePolarity = singleCtrl[clock_output_channel_pkg::POS_NEG_POL +: 2];
  // codes 110 and 111 hand the pins to the single-ended legs
  assign singleMode = diffDriverStandard >= clock_output_channel_pkg::STD_SINGLE_FIRST;
  // edge taken from the second and third stages, never the first
  assign syncEdge = syncSafe && !syncLast;

  // polarity selector shared by all three drivers
  function automatic logic applyPolarity(input logic c, input logic [1:0] code);
    logic r;
    unique case (code)
      clock_output_channel_pkg::POL_FORCE_HIGH: r = 1'b1;
      clock_output_channel_pkg::POL_NONINVERT: r = c;
      clock_output_channel_pkg::POL_INVERT: r = !c;
      clock_output_channel_pkg::POL_FORCE_LOW: r = 1'b0;
    endcase
    return r;
  endfunction

  // register writes; reserved bits are not stored and read back zero
  always_comb begin
    next_chanDivideRatio = chanDivideRatio;
    next_chanPhaseOffset = chanPhaseOffset;
    next_driverCtrl = driverCtrl;
    next_singleCtrl = singleCtrl;
    if (regWrEn) begin
      unique case (regAddr)
        clock_output_channel_pkg::ADDR_RATIO_LOW: next_chanDivideRatio[7:0] = regWrData;
        clock_output_channel_pkg::ADDR_RATIO_HIGH:
          next_chanDivideRatio[9:8] = regWrData[1:0];
        clock_output_channel_pkg::ADDR_PHASE_LOW: next_chanPhaseOffset[7:0] = regWrData;
        clock_output_channel_pkg::ADDR_PHASE_HIGH:
          next_chanPhaseOffset[10:8] = regWrData[2:0];
        clock_output_channel_pkg::ADDR_DRIVER_CTRL: next_driverCtrl = {regWrData[7:1], 1'b0};
        clock_output_channel_pkg::ADDR_SINGLE_CTRL: next_singleCtrl = {regWrData[7:2], 2'b00};
        default: begin
          next_singleCtrl = singleCtrl; // other channels' addresses are ignored
        end
      endcase
    end
  end

  // read data; unmapped addresses answer zero
  always_comb begin
    unique case (regAddr)
      clock_output_channel_pkg::ADDR_RATIO_LOW: next_regRdData = chanDivideRatio[7:0];
      clock_output_channel_pkg::ADDR_RATIO_HIGH: next_regRdData = {6'h00, chanDivideRatio[9:8]};
      clock_output_channel_pkg::ADDR_PHASE_LOW: next_regRdData = chanPhaseOffset[7:0];
      clock_output_channel_pkg::ADDR_PHASE_HIGH: next_regRdData = {5'h00, chanPhaseOffset[10:8]};
      clock_output_channel_pkg::ADDR_DRIVER_CTRL: next_regRdData = driverCtrl;
      clock_output_channel_pkg::ADDR_SINGLE_CTRL: next_regRdData = singleCtrl;
      default: next_regRdData = 8'h00;
    endcase
  end

  // sync request: masked channels never see it
  always_comb begin
    next_syncPulse = syncEdge && !syncExclude;
  end

  // pin drive; every pin is one flop after the divided clock
  always_comb begin
    next_diffStandard = diffDriverStandard;
    next_halfShift = cfgBus.halfShift;
    if (singleMode) begin
      next_chanPosOe = posLegSingleEnable;
      next_chanPosPin = posLegSingleEnable && applyPolarity(cfgBus.divClk, posLegSinglePolarity);
      next_chanNegOe = negLegSingleEnable;
      next_chanNegPin = negLegSingleEnable && applyPolarity(cfgBus.divClk, negLegSinglePolarity);
    end else begin
      next_chanPosOe = 1'b1;
      next_chanNegOe = 1'b1;
      next_chanPosPin = applyPolarity(cfgBus.divClk, diffDriverPolarity);
      next_chanNegPin = !applyPolarity(cfgBus.divClk, diffDriverPolarity);
    end
  end

  // all state registers; reset puts the documented defaults in place
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanDivideRatio <= clock_output_channel_pkg::RESET_RATIO;
      chanPhaseOffset <= clock_output_channel_pkg::RESET_PHASE;
      driverCtrl <= clock_output_channel_pkg::RESET_DRIVER_CTRL;
      singleCtrl <= clock_output_channel_pkg::RESET_SINGLE_CTRL;
      regRdData <= 8'h00;
      syncMeta <= 1'b0;
      syncSafe <= 1'b0;
      syncLast <= 1'b0;
      syncPulse <= 1'b0;
      chanPosPin <= 1'b0;
      chanPosOe <= 1'b0;
      chanNegPin <= 1'b0;
      chanNegOe <= 1'b0;
      diffStandard <= 3'h0;
      halfShift <= 1'b0;
    end else begin
      chanDivideRatio <= next_chanDivideRatio;
      chanPhaseOffset <= next_chanPhaseOffset;
      driverCtrl <= next_driverCtrl;
      singleCtrl <= next_singleCtrl;
      regRdData <= next_regRdData;
      syncMeta <= syncReq;
      syncSafe <= syncMeta;
      syncLast <= syncSafe;
      syncPulse <= next_syncPulse;
      chanPosPin <= next_chanPosPin;
      chanPosOe <= next_chanPosOe;
      chanNegPin <= next_chanNegPin;
      chanNegOe <= next_chanNegOe;
      diffStandard <= next_diffStandard;
      halfShift <= next_halfShift;
    end
  end

  // settings to the divider
  assign cfgBus.ratio = chanDivideRatio;
  assign cfgBus.phase = chanPhaseOffset;
  assign cfgBus.powerdown = dividerPowerdown;
  assign cfgBus.syncPulse = syncPulse;

  channel_divider divider (
    .clk(clk),
    .rst(rst),
    .cfg(cfgBus.div)
  );

  chk_ratio_low: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_RATIO_LOW)
      |=> chanDivideRatio[7:0] == $past(regWrData))
    else $error("ratio low byte not stored");
  chk_ratio_high: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_RATIO_HIGH)
      |=> chanDivideRatio[9:8] == $past(regWrData[1:0]) ##1 regRdData[7:2] == 6'h00)
    else $error("ratio high bits not stored");
  chk_phase_bytes: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_PHASE_HIGH)
      |=> chanPhaseOffset[10:8] == $past(regWrData[2:0]))
    else $error("offset high bits not stored");
  chk_sync_masked: assert property (@(posedge clk) disable iff (rst)
    syncEdge |=> syncPulse == !$past(syncExclude))
    else $error("sync exclude not honoured");
  chk_diff_force: assert property (@(posedge clk) disable iff (rst)
    (!singleMode && diffDriverPolarity == clock_output_channel_pkg::POL_FORCE_HIGH)
      |=> chanPosPin && !chanNegPin && chanPosOe)
    else $error("differential force high wrong");
  chk_diff_invert: assert property (@(posedge clk) disable iff (rst)
    (!singleMode && diffDriverPolarity == clock_output_channel_pkg::POL_INVERT)
      |=> chanPosPin == !$past(cfgBus.divClk))
    else $error("differential invert wrong");
  chk_mode_single: assert property (@(posedge clk) disable iff (rst)
    singleMode |=> chanPosOe == $past(posLegSingleEnable)
      && chanNegOe == $past(negLegSingleEnable))
    else $error("single-ended mode enables wrong");
  chk_pos_disabled: assert property (@(posedge clk) disable iff (rst)
    (singleMode && !posLegSingleEnable) |=> !chanPosOe && !chanPosPin)
    else $error("positive leg driven while disabled");
  chk_pos_polarity: assert property (@(posedge clk) disable iff (rst)
    (singleMode && posLegSingleEnable
      && posLegSinglePolarity == clock_output_channel_pkg::POL_NONINVERT)
      |=> chanPosPin == $past(cfgBus.divClk))
    else $error("positive leg polarity wrong");
  chk_neg_disabled: assert property (@(posedge clk) disable iff (rst)
    (singleMode && !negLegSingleEnable) |=> !chanNegOe)
    else $error("negative leg driven while disabled");
  chk_neg_polarity: assert property (@(posedge clk) disable iff (rst)
    (singleMode && negLegSingleEnable
      && negLegSinglePolarity == clock_output_channel_pkg::POL_FORCE_LOW)
      |=> !chanNegPin && chanNegOe)
    else $error("negative leg polarity wrong");
  // register port: stored bits and read-back
  chk_phase_low: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_PHASE_LOW)
      |=> chanPhaseOffset[7:0] == $past(regWrData))
    else $error("offset low byte not stored");
  chk_driver_fields: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_DRIVER_CTRL)
      |=> driverCtrl[7:1] == $past(regWrData[7:1]) && driverCtrl[0] == 1'b0)
    else $error("driver control fields not stored");
  chk_single_fields: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == clock_output_channel_pkg::ADDR_SINGLE_CTRL)
      |=> singleCtrl[7:2] == $past(regWrData[7:2]) && singleCtrl[1:0] == 2'b00)
    else $error("single-ended control fields not stored");
  chk_read_ratio: assert property (@(posedge clk) disable iff (rst)
    regAddr == clock_output_channel_pkg::ADDR_RATIO_LOW |=> regRdData == $past(chanDivideRatio[7:0]))
    else $error("ratio low byte read back wrong");
  chk_read_phase: assert property (@(posedge clk) disable iff (rst)
    regAddr == clock_output_channel_pkg::ADDR_PHASE_HIGH |=> regRdData[2:0] == $past(chanPhaseOffset[10:8]))
    else $error("offset high bits read back wrong");
  // pin drive and driver mode
  chk_diff_pass: assert property (@(posedge clk) disable iff (rst)
    (!singleMode && diffDriverPolarity == clock_output_channel_pkg::POL_NONINVERT)
      |=> chanPosPin == $past(cfgBus.divClk)
      && chanNegPin == !$past(cfgBus.divClk))
    else $error("differential pass-through wrong");
  chk_diff_low: assert property (@(posedge clk) disable iff (rst)
    (!singleMode && diffDriverPolarity == clock_output_channel_pkg::POL_FORCE_LOW)
      |=> !chanPosPin && chanNegPin && chanNegOe)
    else $error("differential force low wrong");
  chk_std_passed: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> diffStandard == $past(diffDriverStandard))
    else $error("driver mode code not passed on");
  chk_mode_diff: assert property (@(posedge clk) disable iff (rst)
    !singleMode |=> chanPosOe && chanNegOe)
    else $error("differential mode not driving both pins");
  chk_pos_force: assert property (@(posedge clk) disable iff (rst)
    (singleMode && posLegSingleEnable
      && posLegSinglePolarity == clock_output_channel_pkg::POL_FORCE_HIGH) |=> chanPosPin && chanPosOe)
    else $error("positive leg force high wrong");
  chk_neg_invert: assert property (@(posedge clk) disable iff (rst)
    (singleMode && negLegSingleEnable
      && negLegSinglePolarity == clock_output_channel_pkg::POL_INVERT)
      |=> chanNegPin == !$past(cfgBus.divClk))
    else $error("negative leg invert wrong");
  chk_neg_quiet: assert property (@(posedge clk) disable iff (rst)
    (singleMode && !negLegSingleEnable) |=> !chanNegPin)
    else $error("negative leg pin high while disabled");
  // sync mask and offset hand-off
  chk_sync_blocked: assert property (@(posedge clk) disable iff (rst)
    syncExclude |=> !syncPulse)
    else $error("sync reached an excluded divider");
  chk_half_shift: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> halfShift == $past(cfgBus.halfShift))
    else $error("odd half of offset not reported");
  cover_sync_taken: cover property (@(posedge clk) disable iff (rst)
    syncEdge && !syncExclude);
  cover_powerdown: cover property (@(posedge clk) disable iff (rst)
    dividerPowerdown ##1 !dividerPowerdown);
  cover_single_mode: cover property (@(posedge clk) disable iff (rst)
    singleMode && posLegSingleEnable && negLegSingleEnable);
  cover_diff_hstl: cover property (@(posedge clk) disable iff (rst)
    diffDriverStandard == clock_output_channel_pkg::STD_HSTL_BOOST);
endmodule // clock_output_channel_ctrl

// [bench/clock_sink.sv]
// Purpose: downstream receiver timing the channel positive pin
// Assumes: pin sampled on the channel input clock
// Notes: divide-by-1 shows as a steady level, so no period is seen
`timescale 1ns/1ns
module clock_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic oe,
  output logic [11:0] period,
  output logic [15:0] risings
);
  logic lastPin;
  logic [11:0] count;
  // cycles between rising edges, only while the pin is driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastPin <= 1'b0;
      count <= 12'h000;
      period <= 12'h000;
      risings <= 16'h0000;
    end else begin
      lastPin <= pin & oe;
      if (pin & oe & ~lastPin) begin
        period <= count + 12'h001;
        count <= 12'h000;
        risings <= risings + 16'h0001;
      end else begin
        count <= count + 12'h001;
      end
    end
  end
endmodule // clock_sink

// [bench/clock_output_channel_ctrl_bench.sv]
// Purpose: self-checking bench for one clock output channel
// Assumes: register port and sync pin driven 1 ns after the rising edge
// Notes: ratio 0 keeps the pin high, so a sync shows as a low gap
`timescale 1ns/1ns
module clock_output_channel_ctrl_bench;
  logic clk, rst, regWrEn, syncReq;
  logic [7:0] regAddr, regWrData, regRdData;
  logic chanPosPin, chanPosOe, chanNegPin, chanNegOe, halfShift;
  logic [2:0] diffStandard;
  logic [11:0] period;
  logic [15:0] risings, riseMark;
  int failCount, checked, lowCnt;
  logic [7:0] addrs [6];
  logic [7:0] rstVals [6];
  logic [7:0] fullVals [6];
  logic [3:0] polHigh;

  clock_output_channel_ctrl uut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .syncReq(syncReq),
    .chanPosPin(chanPosPin), .chanPosOe(chanPosOe), .chanNegPin(chanNegPin),
    .chanNegOe(chanNegOe), .diffStandard(diffStandard), .halfShift(halfShift));
  clock_sink sink (.clk(clk), .rst(rst), .pin(chanPosPin), .oe(chanPosOe),
    .period(period), .risings(risings));

  // 25 MHz input clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step();
    regWrEn = 1'b0;
    step();
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    step();
    check({8'h00, regRdData}, {8'h00, exp}, "register read");
  endtask

  // raise sync and count the low cycles the pin shows afterwards
  task automatic syncLow(output int n);
    int waitCnt;
    n = 0;
    waitCnt = 0;
    syncReq = 1'b1;
    while (chanPosPin !== 1'b0 && waitCnt < 12) begin
      step();
      waitCnt++;
    end
    while (chanPosPin === 1'b0 && n < 1100) begin
      step();
      n++;
    end
    syncReq = 1'b0;
    repeat (4) step();
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the tests need about 4100 cycles
  initial begin
    #400000;
    failCount++;
    results();
  end

  initial begin
    addrs = '{clock_output_channel_pkg::ADDR_RATIO_LOW, clock_output_channel_pkg::ADDR_RATIO_HIGH,
      clock_output_channel_pkg::ADDR_PHASE_LOW, clock_output_channel_pkg::ADDR_PHASE_HIGH,
      clock_output_channel_pkg::ADDR_DRIVER_CTRL, clock_output_channel_pkg::ADDR_SINGLE_CTRL};
    rstVals = '{8'h00, 8'h00, 8'h00, 8'h00, clock_output_channel_pkg::RESET_DRIVER_CTRL,
      clock_output_channel_pkg::RESET_SINGLE_CTRL};
    fullVals = '{8'hFF, 8'h03, 8'hFF, 8'h07, 8'hFE, 8'hFC};
    polHigh = 4'h3; // pin level for a high clock per polarity code
    failCount = 0;
    checked = 0;
    rst = 1'b1;
    regWrEn = 1'b0;
    syncReq = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    step();
    // reset values, reserved bits, unmapped place
    for (int i = 0; i < 6; i++) rdChk(addrs[i], rstVals[i]);
    for (int i = 0; i < 6; i++) wr(addrs[i], 8'hFF);
    wr(8'h21, 8'hFF);
    for (int i = 0; i < 6; i++) rdChk(addrs[i], fullVals[i]);
    rdChk(8'h21, 8'h00);
    for (int i = 0; i < 6; i++) wr(addrs[i], rstVals[i]);
    $display("test registers done");
    // driver mode codes and differential enables
    for (int c = 0; c < 8; c++) begin
      wr(8'h1F, {4'h1, c[2:0], 1'b0});
      step();
      check({13'h0, diffStandard}, c[15:0], "driver mode");
      check({15'h0, chanPosOe}, {15'h0, c < 6}, "pos drive enable");
      check({15'h0, chanNegOe}, {15'h0, c < 6}, "neg drive enable");
    end
    // differential polarity with the clock held high by ratio 0
    for (int p = 0; p < 4; p++) begin
      wr(8'h1F, {2'b00, p[1:0], 4'h4});
      step();
      check({14'h0, chanPosPin, chanNegPin}, {14'h0, polHigh[p], ~polHigh[p]}, "diff pol");
    end
    $display("test driver modes done");
    // single-ended legs, one enabled at a time
    wr(8'h1F, 8'h1C);
    for (int p = 0; p < 4; p++) begin
      wr(8'h20, {1'b1, p[1:0], 1'b0, p[1:0], 2'b00});
      step();
      check({12'h0, chanPosOe, chanPosPin, chanNegOe, chanNegPin},
        {12'h0, 1'b1, polHigh[p], 2'b00}, "pos leg");
      wr(8'h20, {1'b0, p[1:0], 1'b1, p[1:0], 2'b00});
      step();
      check({12'h0, chanPosOe, chanPosPin, chanNegOe, chanNegPin},
        {12'h0, 2'b00, 1'b1, polHigh[p]}, "neg leg");
    end
    wr(8'h20, 8'h00);
    wr(8'h1F, 8'h14);
    $display("test single-ended done");
    // offsets: start gap of offset/2 + 1 cycles, odd half reported
    wr(8'h1D, 8'h00);
    syncLow(lowCnt);
    check(lowCnt[15:0], 16'h0001, "gap offset 0");
    check({15'h0, halfShift}, 16'h0000, "half shift 0");
    wr(8'h1D, 8'h04);
    syncLow(lowCnt);
    check(lowCnt[15:0], 16'h0003, "gap offset 4");
    wr(8'h1D, 8'hFF);
    wr(8'h1E, 8'h07);
    syncLow(lowCnt);
    check(lowCnt[15:0], 16'd1024, "gap offset 2047");
    check({15'h0, halfShift}, 16'h0001, "half shift odd");
    // excluded channel ignores sync
    wr(8'h1E, 8'h00);
    wr(8'h1D, 8'h04);
    wr(8'h1F, 8'h54);
    syncLow(lowCnt);
    check(lowCnt[15:0], 16'h0000, "excluded sync");
    wr(8'h1F, 8'h14);
    syncLow(lowCnt);
    check(lowCnt[15:0], 16'h0003, "included sync");
    $display("test sync done");
    // powerdown holds the pin static, clearing restarts
    wr(8'h1B, 8'h03);
    repeat (20) step();
    wr(8'h1F, 8'h94);
    repeat (4) step();
    riseMark = risings;
    repeat (20) step();
    check(risings, riseMark, "powerdown rises");
    check({15'h0, chanPosPin}, 16'h0000, "powerdown level");
    // parked low clock tells pass from force high and invert from force low
    for (int p = 0; p < 4; p++) begin
      wr(8'h1F, {2'b10, p[1:0], 4'h4});
      step();
      check({14'h0, chanPosPin, chanNegPin}, {14'h0, ~p[0], p[0]}, "parked pol");
    end
    wr(8'h1F, 8'h14);
    repeat (20) step();
    check({4'h0, period}, 16'h0004, "restart period");
    // divide ratios up to the 1024 boundary
    wr(8'h1B, 8'h00);
    wr(8'h1C, 8'h01);
    repeat (600) step();
    check({4'h0, period}, 16'd257, "divide 257");
    wr(8'h1B, 8'hFF);
    wr(8'h1C, 8'h03);
    repeat (2200) step();
    check({4'h0, period}, 16'd1024, "divide 1024");
    $display("test dividers done");
    results();
  end
endmodule // clock_output_channel_ctrl_bench
